// *** pos_pin_drv.sv ***
// One output channel: polarity, steering, shutdown state and pin relocation
`timescale 1ns/1ps

module pos_pin_drv (
  input  wire logic       steer_i,
  input  wire logic       pwm_i,
  input  wire logic       invert_i,
  input  wire logic       shut_i,
  input  wire logic [1:0] shut_state_i,
  input  wire logic       latch_i,
  input  wire logic       dir_i,
  input  wire logic       alt_sel_i,
  output logic            main_out_o,
  output logic            main_oe_o,
  output logic            alt_out_o,
  output logic            alt_oe_o
);

  logic val;
  logic oe;

  // Channel value and driver enable
  always_comb begin
    val = latch_i;                                    // [RL18]
    oe  = ~dir_i;                                     // [RL11]
    if (steer_i) begin
      val = pwm_i ^ invert_i;                         // [RL2] [RL3]
      if (shut_i) begin                               // [RL4]
        unique case (shut_state_i)
          pos_pkg::SD_DRIVE_LOW:  val = 1'b0;         // [RL14]
          pos_pkg::SD_DRIVE_HIGH: val = 1'b1;
          default:                oe  = 1'b0;         // Tri-state
        endcase
      end
    end
  end

  // Route to the main or alternate pin position
  always_comb begin
    main_out_o = alt_sel_i ? 1'b0 : val;              // [RL13]
    main_oe_o  = alt_sel_i ? 1'b0 : oe;
    alt_out_o  = alt_sel_i ? val : 1'b0;
    alt_oe_o   = alt_sel_i ? oe : 1'b0;
  end

endmodule : pos_pin_drv

// *** pos_pkg.sv ***
// Constants, register map and field layout of the PWM output steering stage
//------------------------------------------------------------------------------
// Behaviour
// [RL1] Steering active only with mode upper bits 11 and output config 00.
// [RL2] Same modulated signal drives every pin whose steer enable is set.
// [RL3] In steering mode, mode low bits set polarity of the four pins.
// [RL4] Shutdown changes only steer-enabled pins; others stay untouched.
// [RL5] Sync clear: new enables apply at once when written.
// [RL6] Sync set: written enables wait for the next PWM period start.
// [RL7] Mode low bits pick polarity for pair A/C and pair B/D separately.
// [RL8] Software picks polarity before enabling pin drivers.
// [RL9] Software enables mode, waits one full period, then enables drivers.
// [RL10] Timer flag is set when the second PWM period begins.
// [RL11] After reset all pins are high impedance until drivers are enabled.
// [RL12] Software clears direction bits to let a steered pin drive.
// [RL13] Pins may be moved to alternate positions by alternate select register.
// [RL14] Shutdown sets status and puts enabled pairs in high, low or tri-state.
// [RL15] Shutdown from low level on int pin or high comparator, per select.
// [RL16] With auto-restart, hardware clears status once condition is gone.
// [RL17] After shutdown clears, output resumes at next period start.
// [RL18] Non-steered pins follow the port data latch, no PWM.
// [RL19] Sync set: shadow enables copied to active enables at period boundary.
//------------------------------------------------------------------------------
package pos_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_MODE     = 8'h00;
  localparam logic [7:0] ADDR_ASD      = 8'h04;
  localparam logic [7:0] ADDR_TSEL     = 8'h08;
  localparam logic [7:0] ADDR_STEER    = 8'h0c;
  localparam logic [7:0] ADDR_RESTART  = 8'h10;
  localparam logic [7:0] ADDR_DIR      = 8'h14;
  localparam logic [7:0] ADDR_LATCH    = 8'h18;
  localparam logic [7:0] ADDR_ALT0     = 8'h1c;
  localparam logic [7:0] ADDR_INT_STAT = 8'h20;
  localparam logic [7:0] ADDR_INT_MASK = 8'h24;
  localparam logic [7:0] ADDR_STATUS   = 8'h28;

  // Field positions
  localparam int MODE_CFG_HI   = 7;
  localparam int MODE_CFG_LO   = 6;
  localparam int ASD_STAT_BIT  = 7;
  localparam int STEER_SYNC    = 4;
  localparam int RESTART_BIT   = 7;

  // Field values
  localparam logic [1:0] MODE_PWM_SEL   = 2'h3;
  localparam logic [1:0] CFG_SINGLE     = 2'h0;
  localparam logic [1:0] SD_DRIVE_LOW   = 2'h0;
  localparam logic [1:0] SD_DRIVE_HIGH  = 2'h1;
  localparam logic [1:0] TSEL_NONE      = 2'h3;

  // Interrupt status bits
  localparam int INT_FIRST_CYCLE = 0;
  localparam int INT_SHUTDOWN    = 1;
  localparam int INT_PERIOD      = 2;

  // Reset values and period count values
  localparam logic [7:0] RST_MODE   = 8'h00;
  localparam logic [7:0] RST_ASD    = 8'h00;
  localparam logic [7:0] RST_TSEL   = 8'h00;
  localparam logic [3:0] RST_STEER  = 4'h1;
  localparam logic [7:0] RST_RESTRT = 8'h00;
  localparam logic [3:0] RST_DIR    = 4'hf;
  localparam logic [3:0] RST_LATCH  = 4'h0;
  localparam logic [3:0] RST_ALT    = 4'h0;
  localparam logic [2:0] RST_INT    = 3'h0;
  localparam logic [1:0] CNT_SECOND = 2'h1;
  localparam logic [1:0] CNT_DONE   = 2'h2;

endpackage : pos_pkg

// *** pos_steering.sv ***
// PWM output steering stage with APB registers, shutdown and start-up flag
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module pos_steering (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Time base and modulated signal
  input  wire logic        pwm_raw_i,
  input  wire logic [2:0]  period_start_i,
  // Shutdown sources
  input  wire logic        int_pin_i,
  input  wire logic [1:0]  comp_i,
  // Pins
  output logic [3:0]       pwm_out_o,
  output logic [3:0]       pwm_oe_o,
  output logic [3:0]       alt_out_o,
  output logic [3:0]       alt_oe_o,
  output logic             timer_match_flag_o,
  output logic             irq_o
);

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  mode;
    logic [2:0]  sd_src;
    logic [1:0]  ac_st;
    logic [1:0]  bd_st;
    logic        sd_stat;
    logic [7:0]  tsel;
    logic        sync;
    logic [3:0]  shadow;
    logic [3:0]  active;
    logic [7:0]  restart;
    logic [3:0]  dir;
    logic [3:0]  latch;
    logic [3:0]  alt;
    logic [2:0]  int_stat;
    logic [2:0]  int_mask;
    logic [2:0]  rd_cap;
    logic [31:0] prdata;
    logic        prev_mode;
    logic [1:0]  per_cnt;
    logic        hold;
    logic        tflag;
    logic [3:0]  out;
    logic [3:0]  oe;
    logic [3:0]  aout;
    logic [3:0]  aoe;
  } pos_state_t;

  pos_state_t st;
  pos_state_t next_st;

  logic       steer_mode;
  logic       period;
  logic       sd_cond;
  logic       shut;
  logic       setup;
  logic       wr;
  logic       mapped;
  logic [3:0] drv_out;
  logic [3:0] drv_oe;
  logic [3:0] drv_aout;
  logic [3:0] drv_aoe;
  logic [2:0] events;

  //----------------------------------------------------------------------------
  // Decode of mode, time base and shutdown sources
  //----------------------------------------------------------------------------
  // Steering mode and period strobe of the selected timer
  assign steer_mode = (st.mode[3:2] == pos_pkg::MODE_PWM_SEL) &&
                      (st.mode[pos_pkg::MODE_CFG_HI:pos_pkg::MODE_CFG_LO]
                       == pos_pkg::CFG_SINGLE);                              // [RL1]
  assign period     = (st.tsel[1:0] != pos_pkg::TSEL_NONE) &&
                      period_start_i[st.tsel[1:0]];

  // Level-based shutdown condition from the selected sources
  assign sd_cond = (st.sd_src[2] & ~int_pin_i) |
                   (st.sd_src[0] & comp_i[0]) |
                   (st.sd_src[1] & comp_i[1]);                               // [RL15]
  // Outputs go to shutdown state at once and stay there until the first period start after the status clears
  assign shut    = sd_cond | st.sd_stat | st.hold;                           // [RL17]

  // APB phases and address decode
  assign setup  = psel_i & ~penable_i;
  assign wr     = psel_i & penable_i & pwrite_i;
  always_comb begin
    unique case (paddr_i)
      pos_pkg::ADDR_MODE, pos_pkg::ADDR_ASD, pos_pkg::ADDR_TSEL,
      pos_pkg::ADDR_STEER, pos_pkg::ADDR_RESTART, pos_pkg::ADDR_DIR,
      pos_pkg::ADDR_LATCH, pos_pkg::ADDR_ALT0, pos_pkg::ADDR_INT_STAT,
      pos_pkg::ADDR_INT_MASK, pos_pkg::ADDR_STATUS: mapped = 1'b1;
      default:                                      mapped = 1'b0;
    endcase
  end

  //----------------------------------------------------------------------------
  // Pin channels
  //----------------------------------------------------------------------------
  // Channels 0 and 2 form pair A/C, channels 1 and 3 pair B/D
  for (genvar i = 0; i < 4; i++) begin : g_pin
    pos_pin_drv u_drv (
      .steer_i      (steer_mode & st.active[i]),
      .pwm_i        (pwm_raw_i),
      .invert_i     ((i % 2 == 0) ? st.mode[1] : st.mode[0]),               // [RL7]
      .shut_i       (shut),
      .shut_state_i ((i % 2 == 0) ? st.ac_st : st.bd_st),
      .latch_i      (st.latch[i]),
      .dir_i        (st.dir[i]),
      .alt_sel_i    (st.alt[i]),
      .main_out_o   (drv_out[i]),
      .main_oe_o    (drv_oe[i]),
      .alt_out_o    (drv_aout[i]),
      .alt_oe_o     (drv_aoe[i])
    );
  end

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    events  = 3'h0;

    // Pin drivers registered
    next_st.out  = drv_out;
    next_st.oe   = drv_oe;
    next_st.aout = drv_aout;
    next_st.aoe  = drv_aoe;

    // Read data captured in setup phase, unmapped reads as zero
    if (setup && !pwrite_i) begin
      next_st.prdata = 32'h0;
      next_st.rd_cap = 3'h0;
      unique case (paddr_i)
        pos_pkg::ADDR_MODE:     next_st.prdata[7:0] = st.mode;
        pos_pkg::ADDR_ASD:      next_st.prdata[7:0] = {st.sd_stat, st.sd_src,
                                                       st.ac_st, st.bd_st};
        pos_pkg::ADDR_TSEL:     next_st.prdata[7:0] = st.tsel;
        pos_pkg::ADDR_STEER:    next_st.prdata[4:0] = {st.sync, st.shadow};
        pos_pkg::ADDR_RESTART:  next_st.prdata[7:0] = st.restart;
        pos_pkg::ADDR_DIR:      next_st.prdata[3:0] = st.dir;
        pos_pkg::ADDR_LATCH:    next_st.prdata[3:0] = st.latch;
        pos_pkg::ADDR_ALT0:     next_st.prdata[3:0] = st.alt;
        pos_pkg::ADDR_INT_STAT: begin
          next_st.prdata[2:0] = st.int_stat;
          next_st.rd_cap      = st.int_stat;
        end
        pos_pkg::ADDR_INT_MASK: next_st.prdata[2:0] = st.int_mask;
        pos_pkg::ADDR_STATUS:   next_st.prdata[10:0] = {st.tflag, shut, steer_mode,
                                                        st.active, st.oe};
        default:                next_st.prdata = 32'h0;
      endcase
    end

    // Read of interrupt status clears only the bits that were returned
    if (psel_i && penable_i && !pwrite_i && paddr_i == pos_pkg::ADDR_INT_STAT) begin
      next_st.int_stat = st.int_stat & ~st.rd_cap;
    end

    // Register writes at the access edge
    if (wr) begin
      unique case (paddr_i)
        pos_pkg::ADDR_MODE:     next_st.mode = pwdata_i[7:0];
        pos_pkg::ADDR_ASD: begin
          next_st.sd_src = pwdata_i[6:4];
          next_st.ac_st  = pwdata_i[3:2];
          next_st.bd_st  = pwdata_i[1:0];
          if (!sd_cond) begin
            next_st.sd_stat = pwdata_i[pos_pkg::ASD_STAT_BIT];  // Software shutdown or clear
          end
        end
        pos_pkg::ADDR_TSEL:     next_st.tsel = pwdata_i[7:0];
        pos_pkg::ADDR_STEER: begin
          next_st.sync   = pwdata_i[pos_pkg::STEER_SYNC];
          next_st.shadow = pwdata_i[3:0];                       // [RL19]
          if (!pwdata_i[pos_pkg::STEER_SYNC]) begin
            next_st.active = pwdata_i[3:0];                     // [RL5]
          end
        end
        pos_pkg::ADDR_RESTART:  next_st.restart = pwdata_i[7:0];
        pos_pkg::ADDR_DIR:      next_st.dir = pwdata_i[3:0];
        pos_pkg::ADDR_LATCH:    next_st.latch = pwdata_i[3:0];
        pos_pkg::ADDR_ALT0:     next_st.alt = pwdata_i[3:0];
        pos_pkg::ADDR_INT_MASK: next_st.int_mask = pwdata_i[2:0];
        default:                next_st.int_mask = st.int_mask;
      endcase
    end

    // Period boundary: synchronised steering update
    if (period && st.sync) begin
      next_st.active = st.shadow;                               // [RL6] [RL19]
    end

    // Shutdown status: set by condition, auto-cleared when restart enabled
    if (sd_cond) begin
      next_st.sd_stat = 1'b1;                                   // [RL14]
      next_st.hold    = 1'b1;
      if (!st.sd_stat) begin
        events[pos_pkg::INT_SHUTDOWN] = 1'b1;
      end
    end else if (st.restart[pos_pkg::RESTART_BIT]) begin
      next_st.sd_stat = 1'b0;                                   // [RL16]
    end
    if (next_st.sd_stat) begin
      next_st.hold = 1'b1;
    end else if (period) begin
      next_st.hold = 1'b0;                                      // [RL17]
    end

    // Count periods after steering mode starts, flag the second period
    next_st.prev_mode = steer_mode;
    if (steer_mode && !st.prev_mode) begin
      next_st.per_cnt = 2'h0;
    end else if (steer_mode && period && st.per_cnt != pos_pkg::CNT_DONE) begin
      next_st.per_cnt = st.per_cnt + 2'h1;
      if (st.per_cnt == pos_pkg::CNT_SECOND) begin
        next_st.tflag = 1'b1;                                   // [RL10]
        events[pos_pkg::INT_FIRST_CYCLE] = 1'b1;
      end
    end
    if (!steer_mode) begin
      next_st.tflag = 1'b0;
    end
    events[pos_pkg::INT_PERIOD] = period;

    // New events win over a clearing read
    next_st.int_stat = next_st.int_stat | events;
  end

  //----------------------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      st          <= '0;
      st.mode     <= pos_pkg::RST_MODE;
      st.sd_src   <= pos_pkg::RST_ASD[6:4];
      st.tsel     <= pos_pkg::RST_TSEL;
      st.shadow   <= pos_pkg::RST_STEER;
      st.active   <= pos_pkg::RST_STEER;
      st.restart  <= pos_pkg::RST_RESTRT;
      st.dir      <= pos_pkg::RST_DIR;                          // [RL11]
      st.latch    <= pos_pkg::RST_LATCH;
      st.alt      <= pos_pkg::RST_ALT;
      st.int_stat <= pos_pkg::RST_INT;
      st.int_mask <= pos_pkg::RST_INT;
    end else begin
      st <= next_st;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  assign prdata_o           = st.prdata;
  assign pready_o           = 1'b1;                             // Zero wait states
  assign pslverr_o          = psel_i & penable_i & ~mapped;
  assign pwm_out_o          = st.out;
  assign pwm_oe_o           = st.oe;
  assign alt_out_o          = st.aout;
  assign alt_oe_o           = st.aoe;
  assign timer_match_flag_o = st.tflag;
  assign irq_o              = |(st.int_stat & st.int_mask);

endmodule : pos_steering

// *** pos_steering_assertions.sv ***
// Port-level assertions of the PWM output steering stage
`timescale 1ns/1ps
module pos_steering_assertions (
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pwm_raw_i,
  input wire logic [2:0]  period_start_i,
  input wire logic        int_pin_i,
  input wire logic [1:0]  comp_i,
  input wire logic [3:0]  pwm_out_o,
  input wire logic [3:0]  pwm_oe_o,
  input wire logic        timer_match_flag_o
);
  logic [7:0] mode_q;
  logic [7:0] asd_q;
  logic [1:0] tsel_q;
  logic [3:0] dir_q;
  logic [3:0] lat_q;
  logic [3:0] alt_q;
  logic [3:0] en_q;
  logic [3:0] sh_q;
  logic       calm_q;
  logic       wr;
  logic       pulse;
  logic       steer;
  logic       cond;
  logic       quiet;
  logic       sdx;
  logic [3:0] inv;
  logic [3:0] exp_n;
  logic [3:0] sd_lvl;
  logic [3:0] sd_tri;
  logic [3:0] sd_drv;

  // Decoded view of the snooped registers
  assign wr     = psel_i && penable_i && pwrite_i;
  assign pulse  = tsel_q != pos_pkg::TSEL_NONE && period_start_i[tsel_q];
  assign steer  = mode_q[3:2] == pos_pkg::MODE_PWM_SEL && mode_q[7:6] == pos_pkg::CFG_SINGLE;
  assign cond   = (asd_q[6] && !int_pin_i) || (asd_q[4] && comp_i[0]) || (asd_q[5] && comp_i[1]);
  assign quiet  = calm_q && asd_q[7:4] == 4'h0 && alt_q == 4'h0;
  assign sdx    = steer && cond && alt_q == 4'h0;
  assign inv    = {mode_q[0], mode_q[1], mode_q[0], mode_q[1]};
  assign exp_n  = (en_q & ({4{pwm_raw_i}} ^ inv)) | (~en_q & lat_q);
  assign sd_lvl = {asd_q[0], asd_q[2], asd_q[0], asd_q[2]};
  assign sd_tri = en_q & {asd_q[1], asd_q[3], asd_q[1], asd_q[3]};
  assign sd_drv = en_q & ~sd_tri;

  // Register snoop from completed APB writes
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      mode_q <= pos_pkg::RST_MODE;
      asd_q  <= pos_pkg::RST_ASD;
      tsel_q <= pos_pkg::RST_TSEL[1:0];
      dir_q  <= pos_pkg::RST_DIR;
      lat_q  <= pos_pkg::RST_LATCH;
      alt_q  <= pos_pkg::RST_ALT;
      en_q   <= pos_pkg::RST_STEER;
      sh_q   <= pos_pkg::RST_STEER;
      calm_q <= 1'b1;
    end else begin
      if (wr && paddr_i == pos_pkg::ADDR_MODE) mode_q <= pwdata_i[7:0];
      if (wr && paddr_i == pos_pkg::ADDR_ASD) asd_q <= pwdata_i[7:0];
      if (wr && paddr_i == pos_pkg::ADDR_TSEL) tsel_q <= pwdata_i[1:0];
      if (wr && paddr_i == pos_pkg::ADDR_DIR) dir_q <= pwdata_i[3:0];
      if (wr && paddr_i == pos_pkg::ADDR_LATCH) lat_q <= pwdata_i[3:0];
      if (wr && paddr_i == pos_pkg::ADDR_ALT0) alt_q <= pwdata_i[3:0];
      if (wr && paddr_i == pos_pkg::ADDR_STEER) sh_q <= pwdata_i[3:0];
      if (wr && paddr_i == pos_pkg::ADDR_STEER && !pwdata_i[pos_pkg::STEER_SYNC])
        en_q <= pwdata_i[3:0];
      else if (pulse)
        en_q <= sh_q;
      if (asd_q[7:4] != 4'h0) calm_q <= 1'b0;
      else if (pulse) calm_q <= 1'b1;
    end
  end

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  a_reset_hiz: assert property (
    $rose(resetn_i) |-> pwm_oe_o == 4'h0) else $error("Pin driven at reset release");
  a_steer_out: assert property (
    steer && quiet |=> pwm_out_o == $past(exp_n)) else $error("Steered pin value wrong");
  a_port_mode: assert property (
    !steer && quiet |=> pwm_out_o == $past(lat_q)) else $error("Port pin value wrong");
  a_oe_dir: assert property (
    quiet |=> pwm_oe_o == ~$past(dir_q)) else $error("Driver enable wrong");
  a_sd_level: assert property (
    sdx ##1 cond |=> ((pwm_out_o ^ $past(sd_lvl)) & $past(sd_drv)) == 4'h0)
    else $error("Shutdown level wrong");
  a_sd_tri: assert property (
    sdx ##1 cond |=> (pwm_oe_o & $past(sd_tri)) == 4'h0) else $error("Shutdown tri wrong");
  a_sd_others: assert property (
    sdx ##1 cond |=> ((pwm_out_o ^ $past(lat_q)) & ~$past(en_q)) == 4'h0)
    else $error("Unsteered pin hit by shutdown");
  a_flag_start: assert property (
    $rose(timer_match_flag_o) |-> $past(pulse)) else $error("Flag rose off period");
  c_all_pins: cover property (steer && en_q == 4'hf);
  c_shutdown: cover property (sdx ##1 cond);
  c_flag: cover property ($rose(timer_match_flag_o));
endmodule : pos_steering_assertions

bind pos_steering pos_steering_assertions i_pos_steering_assertions (.*);

// *** pos_switch_model.sv ***
// Model of the external switch drivers on the pins
`timescale 1ns/1ps
module pos_switch_model (
  input  wire logic [3:0] pwm_out_o,
  input  wire logic [3:0] pwm_oe_o,
  input  wire logic [3:0] alt_out_o,
  input  wire logic [3:0] alt_oe_o,
  output logic      [3:0] gate_o
);
  // Pull-downs keep a switch off while its pin floats
  assign gate_o = (pwm_out_o & pwm_oe_o) | (alt_out_o & alt_oe_o);
endmodule : pos_switch_model

// *** tb.sv ***
// Self-checking bench of the PWM output steering stage
`timescale 1ns/1ps
module tb;
  logic        core_clk_i     = 1'b0;
  logic        resetn_i       = 1'b0;
  logic        psel_i         = 1'b0;
  logic        penable_i      = 1'b0;
  logic        pwrite_i       = 1'b0;
  logic [7:0]  paddr_i        = 8'h00;
  logic [31:0] pwdata_i       = 32'h0;
  logic        pwm_raw_i      = 1'b0;
  logic [2:0]  period_start_i = 3'h0;
  logic        int_pin_i      = 1'b1;
  logic [1:0]  comp_i         = 2'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [3:0]  pwm_out_o;
  logic [3:0]  pwm_oe_o;
  logic [3:0]  alt_out_o;
  logic [3:0]  alt_oe_o;
  logic [3:0]  gate_o;
  logic        timer_match_flag_o;
  logic        irq_o;
  logic        err_q;
  logic [31:0] rd;
  int          n_errors   = 0;
  int          num_checks = 0;

  pos_steering     i_pos_steering (.*);
  pos_switch_model i_pos_switch_model (.*);

  // 20 MHz clock
  always #25 core_clk_i = ~core_clk_i;

  //----------------------------------------------------------------------------
  // Shared tasks
  //----------------------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    chk_reg({28'h0, got}, {28'h0, exp});
  endtask : chk_pin

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err_q = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : idle

  task automatic pulse(input logic [2:0] p);
    @(posedge core_clk_i);
    period_start_i <= p;
    @(posedge core_clk_i);
    period_start_i <= 3'h0;
  endtask : pulse

  function automatic logic [3:0] steer_exp(input logic [3:0] en, input logic [1:0] pol,
                                           input logic raw, input logic [3:0] lat);
    logic [3:0] inv;
    inv = {pol[0], pol[1], pol[0], pol[1]};
    return (en & ({4{raw}} ^ inv)) | (~en & lat);
  endfunction : steer_exp

  //----------------------------------------------------------------------------
  // Tests
  //----------------------------------------------------------------------------
  task automatic t_reset;
    logic [3:0] rv [10];
    rv = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'hf, 4'h0, 4'h0, 4'h0, 4'h0};
    chk_pin(pwm_oe_o | alt_oe_o, 4'h0);
    chk_pin(gate_o, 4'h0);
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk_reg(rd, {28'h0, rv[i]});
    end
    apb(1'b0, 8'h2c, 32'h0);
    chk_reg({31'h0, err_q}, 32'h1);
    chk_reg(rd, 32'h0);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_start;
    apb(1'b1, pos_pkg::ADDR_LATCH, 32'h5);
    apb(1'b1, pos_pkg::ADDR_MODE, 32'h0d);
    pulse(3'h1);
    idle(1);
    chk_pin({3'h0, timer_match_flag_o}, 4'h0);
    pulse(3'h1);
    idle(1);
    chk_pin({3'h0, timer_match_flag_o}, 4'h1);
    chk_pin({3'h0, irq_o}, 4'h0);
    apb(1'b1, pos_pkg::ADDR_INT_MASK, 32'h1);
    idle(1);
    chk_pin({3'h0, irq_o}, 4'h1);
    apb(1'b0, pos_pkg::ADDR_INT_STAT, 32'h0);
    chk_reg({31'h0, rd[0]}, 32'h1);
    idle(1);
    chk_pin({3'h0, irq_o}, 4'h0);
    apb(1'b1, pos_pkg::ADDR_DIR, 32'h0);
    $display("t_start done");
  endtask : t_start

  task automatic t_steer;
    logic [3:0] el [5];
    el = '{4'h1, 4'h3, 4'h7, 4'hf, 4'ha};
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, pos_pkg::ADDR_DIR, 32'hf);
      apb(1'b1, pos_pkg::ADDR_MODE, {30'h3, p[1:0]});
      apb(1'b1, pos_pkg::ADDR_DIR, 32'h0);
      foreach (el[k]) begin
        apb(1'b1, pos_pkg::ADDR_STEER, {28'h0, el[k]});
        idle(1);
        chk_pin(gate_o, steer_exp(el[k], p[1:0], pwm_raw_i, 4'h5));
        for (int r = 0; r < 2; r++) begin
          @(posedge core_clk_i);
          pwm_raw_i <= r[0];
          idle(2);
          chk_pin(gate_o, steer_exp(el[k], p[1:0], r[0], 4'h5));
        end
      end
    end
    apb(1'b1, pos_pkg::ADDR_MODE, 32'h4f);
    idle(1);
    chk_pin(gate_o, 4'h5);
    apb(1'b1, pos_pkg::ADDR_ALT0, 32'h1);
    idle(1);
    chk_pin({pwm_oe_o[0], alt_oe_o[0], alt_out_o[0], 1'b0}, 4'h6);
    apb(1'b1, pos_pkg::ADDR_ALT0, 32'h0);
    apb(1'b1, pos_pkg::ADDR_DIR, 32'hf);
    apb(1'b1, pos_pkg::ADDR_MODE, 32'h0c);
    repeat (2) pulse(3'h1);
    apb(1'b1, pos_pkg::ADDR_DIR, 32'h0);
    $display("t_steer done");
  endtask : t_steer

  task automatic t_sync;
    apb(1'b1, pos_pkg::ADDR_LATCH, 32'h0);
    apb(1'b1, pos_pkg::ADDR_TSEL, 32'h1);
    apb(1'b1, pos_pkg::ADDR_STEER, 32'h12);
    idle(2);
    chk_pin(gate_o, 4'ha);
    apb(1'b0, pos_pkg::ADDR_STEER, 32'h0);
    chk_reg(rd, 32'h12);
    pulse(3'h1);
    idle(1);
    chk_pin(gate_o, 4'ha);
    pulse(3'h2);
    idle(1);
    chk_pin(gate_o, 4'h2);
    $display("t_sync done");
  endtask : t_sync

  task automatic t_shut;
    logic [2:0] sl [3];
    logic [3:0] ss [3];
    logic [3:0] gx [3];
    logic [3:0] ox [3];
    sl = '{3'h4, 3'h1, 3'h2};
    ss = '{4'h6, 4'h0, 4'h9};
    gx = '{4'hd, 4'h8, 4'ha};
    ox = '{4'hd, 4'hf, 4'ha};
    @(posedge core_clk_i);
    pwm_raw_i <= 1'b1;
    apb(1'b1, pos_pkg::ADDR_LATCH, 32'h8);
    apb(1'b1, pos_pkg::ADDR_STEER, 32'h07);
    apb(1'b1, pos_pkg::ADDR_RESTART, 32'h80);
    foreach (sl[k]) begin
      apb(1'b1, pos_pkg::ADDR_ASD, {24'h0, 1'b0, sl[k], ss[k]});
      idle(2);
      chk_pin(gate_o, 4'hf);
      @(posedge core_clk_i);
      int_pin_i <= ~sl[k][2];
      comp_i    <= sl[k][1:0];
      idle(2);
      chk_pin(gate_o, gx[k]);
      chk_pin(pwm_oe_o, ox[k]);
      apb(1'b0, pos_pkg::ADDR_ASD, 32'h0);
      chk_reg({31'h0, rd[7]}, 32'h1);
      @(posedge core_clk_i);
      int_pin_i <= 1'b1;
      comp_i    <= 2'h0;
      idle(2);
      apb(1'b0, pos_pkg::ADDR_ASD, 32'h0);
      chk_reg({31'h0, rd[7]}, 32'h0);
      chk_pin(gate_o, gx[k]);
      pulse(3'h2);
      idle(1);
      chk_pin(gate_o, 4'hf);
    end
    apb(1'b0, pos_pkg::ADDR_INT_STAT, 32'h0);
    chk_reg({31'h0, rd[1]}, 32'h1);
    apb(1'b1, pos_pkg::ADDR_ASD, 32'h0);
    $display("t_shut done");
  endtask : t_shut

  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    idle(1);
    t_reset();
    t_start();
    t_steer();
    t_sync();
    t_shut();
    wrap_up();
  end

  // Watchdog against a hung handshake
  initial begin
    #400us;
    n_errors++;
    wrap_up();
  end
endmodule : tb
